//--- backplane_gapped_clock_control.sv
// Backplane gapped clock control: APB registers, reference clock rate
// selection, transmit gapped clock input, receive gapped data output,
// fractional interface pin routing and transmit serial clock shaping.
// Assumes a 250 MHz clk_in, an APB master, and a receive serial clock from
// the backplane that is a second domain when gapped mode is on.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// R01 - Rate bit 0: reference outputs run at 1.544 and 2.048 MHz.
// R02 - Rate bit 1: reference outputs run at 49.408 and 65.536 MHz; here both outputs stay at the base rates and only the select output changes.
// R03 - Transmit gapped mode accepts 2.048 Mbit/s data with 63 gaps.
// R04 - Transmit gapped mode: sync pin is gapped clock, data pin gapped data.
// R05 - Backplane supplies 1.544 MHz on transmit serial clock in gapped mode.
// R06 - Receive gapped mode outputs 2.048 Mbit/s data with 63 gaps.
// R07 - Receive gapped mode makes receive serial clock an input, gapped clock.
// R08 - Receive data gaps sit exactly where the applied clock has gaps.
// R09 - Fractional clock select 0: fractional data clocked by channel clock.
// R10 - Select 1: serial clock clocks data, channel clock pin enables.
// R11 - Fractional interface off: timeslot pins show current time slot; in high speed mode the code drives only pins 4..1, with slot bits 4..1.
// R12 - Base rate, payload bit 0, clock output: continuous 1.544 MHz clock.
// R13 - Base rate, payload bit 1: serial clock pulses only on payload bits.
// R14 - High speed: same bit sets frame boundary polarity, 1 active low.
// R15 - Fractional enable remaps timeslot pins to fractional functions; in high speed mode the code keeps slot bits 4..1 on them instead.
// R16 - Reserved bits read zero and ignore writes.
module backplane_gapped_clock_control
  import bgcc_pkg::*;
#(
  parameter int           CLK_HZ          = 250_000_000,
  parameter int           DS1_HZ          = 1_544_000,
  parameter int           E1_HZ           = 2_048_000
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Reference clocks and their rate
  output logic                   ref_clock_out_t1_out,
  output logic                   ref_clock_out_e1_out,
  output logic                   ref_clock_rate_select_out,
  // Transmit backplane pins
  input  wire logic              tx_multiframe_sync_pin_in,
  input  wire logic              tx_serial_data_pin_in,
  input  wire logic              tx_serial_clock_pin_in,
  output logic                   tx_serial_clock_pin_out,
  output logic                   tx_serial_clock_pin_oe_out,
  input  wire logic              tx_channel_clock_pin_in,
  input  wire logic              tx_frame_boundary_pin_in,
  output logic      [4:0]        timeslot_id_pins_out,
  input  wire logic [4:0]        timeslot_id_pins_in,
  output logic      [4:0]        timeslot_id_pins_oe_out,
  // Transmit data toward the framer core
  output logic                   tx_data_out,
  output logic                   tx_data_valid_out,
  output logic                   tx_frame_start_out,
  output logic                   frac_data_out,
  output logic                   frac_data_valid_out,
  output logic                   frac_sig_out,
  // Receive backplane pins
  input  wire logic              rx_serial_clock_pin_in,
  output logic                   rx_serial_clock_pin_oe_out,
  output logic                   rx_serial_data_pin_out,
  input  wire logic              rx_data_in
);
  import bgcc_pkg::*;

  localparam int DS1_DIV = CLK_HZ / (2 * DS1_HZ);
  localparam int E1_DIV  = CLK_HZ / (2 * E1_HZ);

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ACCESS = 2'b10
  } apb_phase_t;

  typedef struct packed {
    ctrl_t      ctrl;
    apb_phase_t phase;
    logic [31:0] rdata;
    logic [7:0] ds1_cnt;
    logic [7:0] e1_cnt;
    logic       ds1_clk;
    logic       e1_clk;
    logic       tx_clk_prev;
    logic       gap_clk_prev;
    logic       chan_clk_prev;
    logic       ser_clk_prev;
    logic [7:0] bit_pos;
    logic [4:0] slot;
    logic [4:0] frame;
    logic       tx_data;
    logic       tx_valid;
    logic       frame_start;
    logic       frac_data;
    logic       frac_valid;
    logic       frac_sig;
  } state_t;

  state_t state;
  state_t next_state;

  logic [4:0] pins_sync;
  logic       msync_sync;
  logic       ser_sync;
  logic       serclk_sync;
  logic       chclk_sync;
  logic       fbound_sync;

  bgcc_sync #(.WIDTH(10)) u_pin_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({timeslot_id_pins_in, tx_multiframe_sync_pin_in, tx_serial_data_pin_in,
                  tx_serial_clock_pin_in, tx_channel_clock_pin_in, tx_frame_boundary_pin_in}),
    .sync_out   ({pins_sync, msync_sync, ser_sync, serclk_sync, chclk_sync, fbound_sync})
  );

  bgcc_rx_gap u_rx_gap (
    .rx_clk_in              (rx_serial_clock_pin_in),
    .sys_rst_in             (sys_rst_in),
    .gap_enable_in          (state.ctrl.rx_gap_clock_enable),
    .data_in                (rx_data_in),
    .rx_serial_data_pin_out (rx_serial_data_pin_out)   // see R06, see R08
  );

  function automatic logic [31:0] read_reg(input logic [11:0] addr, input ctrl_t c);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      GAP_CTRL_ADDR:
      begin
        v[GCC_REF_RATE_BIT] = c.ref_clock_rate_select;
        v[GCC_TX_GAP_BIT]   = c.tx_gap_clock_enable;
        v[GCC_RX_GAP_BIT]   = c.rx_gap_clock_enable;
      end
      TX_IF_CTRL_ADDR:
      begin
        v[TIC_FRAC_CLK_BIT] = c.frac_clock_select;
        v[TIC_PAYLOAD_BIT]  = c.payload_clock_enable;
        v[TIC_FRAC_EN_BIT]  = c.frac_interface_enable;
      end
      MODE_CTRL_ADDR:
      begin
        v[MODE_HIGH_SPEED_BIT] = c.high_speed_mode;
        v[MODE_TXCLK_OUT_BIT]  = c.tx_serial_clock_is_output;
      end
      default: v = 8'h00;
    endcase
    return {24'h000000, v};   // see R16
  endfunction : read_reg

  function automatic logic addr_ok(input logic [11:0] addr);
    return (addr == GAP_CTRL_ADDR) || (addr == TX_IF_CTRL_ADDR) || (addr == MODE_CTRL_ADDR);
  endfunction : addr_ok

  logic tx_edge;
  logic gap_edge;
  logic chan_edge;
  logic ser_edge;
  logic payload_bit;
  logic boundary_active;

  always_comb
  begin
    next_state = state;
    // APB slave: one wait-free access phase
    unique case (state.phase)
      APB_IDLE:
      begin
        if (psel_in && !penable_in)
        begin
          next_state.phase = APB_ACCESS;
          next_state.rdata = read_reg(paddr_in, state.ctrl);
        end
      end
      APB_ACCESS:
      begin
        next_state.phase = APB_IDLE;
        if (psel_in && penable_in && pwrite_in && addr_ok(paddr_in))
        begin
          unique case (paddr_in)
            GAP_CTRL_ADDR:
            begin
              next_state.ctrl.ref_clock_rate_select = pwdata_in[GCC_REF_RATE_BIT];
              next_state.ctrl.tx_gap_clock_enable   = pwdata_in[GCC_TX_GAP_BIT];
              next_state.ctrl.rx_gap_clock_enable   = pwdata_in[GCC_RX_GAP_BIT];
            end
            TX_IF_CTRL_ADDR:
            begin
              next_state.ctrl.frac_clock_select     = pwdata_in[TIC_FRAC_CLK_BIT];
              next_state.ctrl.payload_clock_enable  = pwdata_in[TIC_PAYLOAD_BIT];
              next_state.ctrl.frac_interface_enable = pwdata_in[TIC_FRAC_EN_BIT];
            end
            default:
            begin
              next_state.ctrl.high_speed_mode           = pwdata_in[MODE_HIGH_SPEED_BIT];
              next_state.ctrl.tx_serial_clock_is_output = pwdata_in[MODE_TXCLK_OUT_BIT];
            end
          endcase
        end
      end
      default: next_state.phase = APB_IDLE;
    endcase

    // Base rate clocks; high rate forms are produced by the clock tree
    if (state.ds1_cnt >= 8'(DS1_DIV - 1))
    begin
      next_state.ds1_cnt = 8'h00;
      next_state.ds1_clk = !state.ds1_clk;
    end
    else
      next_state.ds1_cnt = state.ds1_cnt + 8'h01;
    if (state.e1_cnt >= 8'(E1_DIV - 1))
    begin
      next_state.e1_cnt = 8'h00;
      next_state.e1_clk = !state.e1_clk;
    end
    else
      next_state.e1_cnt = state.e1_cnt + 8'h01;

    // Frame position along the transmit serial clock
    next_state.tx_clk_prev   = state.ds1_clk;
    next_state.gap_clk_prev  = msync_sync;
    next_state.chan_clk_prev = chclk_sync;
    next_state.ser_clk_prev  = serclk_sync;
    next_state.tx_valid      = 1'b0;
    next_state.frac_valid    = 1'b0;
    next_state.frame_start   = 1'b0;
    if (tx_edge)
    begin
      if (state.bit_pos == 8'(DS1_BITS_PER_FRAME - 1))
      begin
        next_state.bit_pos = 8'h00;
        next_state.frame = (state.frame == 5'(DS1_FRAMES_PER_MF - 1)) ? 5'h00
                           : state.frame + 5'h01;
      end
      else
        next_state.bit_pos = state.bit_pos + 8'h01;
      next_state.slot = (state.bit_pos == 8'h00) ? 5'h00 : 5'((state.bit_pos - 8'h01) >> 3);
    end
    if (state.ctrl.high_speed_mode && boundary_active)
      next_state.frame_start = 1'b1;   // see R14

    // Transmit data: gapped clock or serial clock
    if (state.ctrl.tx_gap_clock_enable)
    begin
      if (gap_edge)   // see R03, see R04
      begin
        next_state.tx_data  = ser_sync;
        next_state.tx_valid = 1'b1;
      end
    end
    else if (tx_edge)
    begin
      next_state.tx_data  = ser_sync;
      next_state.tx_valid = 1'b1;
    end

    // Fractional data capture
    if (state.ctrl.frac_interface_enable)
    begin
      if (!state.ctrl.frac_clock_select && chan_edge)   // see R09
      begin
        next_state.frac_data  = pins_sync[1];
        next_state.frac_sig   = pins_sync[0];
        next_state.frac_valid = 1'b1;
      end
      else if (state.ctrl.frac_clock_select && ser_edge && chclk_sync)   // see R10
      begin
        next_state.frac_data  = pins_sync[1];
        next_state.frac_sig   = pins_sync[0];
        next_state.frac_valid = 1'b1;
      end
    end
  end

  assign tx_edge   = state.ds1_clk && !state.tx_clk_prev;
  assign gap_edge  = msync_sync && !state.gap_clk_prev;
  assign chan_edge = chclk_sync && !state.chan_clk_prev;
  assign ser_edge  = serclk_sync && !state.ser_clk_prev;
  assign payload_bit = (state.bit_pos != 8'h00);
  assign boundary_active = state.ctrl.payload_clock_enable ? !fbound_sync : fbound_sync;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state       <= '0;
      state.phase <= APB_IDLE;
    end
    else
      state <= next_state;
  end

  // APB answers
  assign pready_out  = (state.phase == APB_ACCESS);
  assign pslverr_out = (state.phase == APB_ACCESS) && !addr_ok(paddr_in);
  assign prdata_out  = state.rdata;

  // Reference clocks
  assign ref_clock_rate_select_out = state.ctrl.ref_clock_rate_select;   // see R01, see R02
  assign ref_clock_out_t1_out      = state.ds1_clk;   // see R01
  assign ref_clock_out_e1_out      = state.e1_clk;    // see R01

  // Transmit serial clock pin
  always_comb
  begin
    tx_serial_clock_pin_oe_out = state.ctrl.tx_serial_clock_is_output
                                 && !state.ctrl.tx_gap_clock_enable;   // see R05
    if (!state.ctrl.high_speed_mode && state.ctrl.payload_clock_enable)
      // First high cycle held low so a gap never leaves a short pulse
      tx_serial_clock_pin_out = state.ds1_clk && state.tx_clk_prev && payload_bit;   // see R13
    else
      tx_serial_clock_pin_out = state.ds1_clk;   // see R12
  end

  // Timeslot identifier pins
  always_comb
  begin
    if (state.ctrl.frac_interface_enable && !state.ctrl.high_speed_mode)
    begin
      timeslot_id_pins_out    = {1'b0, (state.frame == 5'h00) && (state.bit_pos == 8'h01),
                                 state.e1_clk, 2'b00};   // see R15
      timeslot_id_pins_oe_out = 5'b01100;
    end
    else if (state.ctrl.high_speed_mode)
    begin
      timeslot_id_pins_out    = {state.slot[4:1], 1'b0};
      timeslot_id_pins_oe_out = 5'b11110;
    end
    else
    begin
      timeslot_id_pins_out    = state.slot;   // see R11
      timeslot_id_pins_oe_out = 5'b11111;
    end
  end

  assign rx_serial_clock_pin_oe_out = 1'b0;   // see R07
  assign tx_data_out         = state.tx_data;
  assign tx_data_valid_out   = state.tx_valid;
  assign tx_frame_start_out  = state.frame_start;
  assign frac_data_out       = state.frac_data;
  assign frac_data_valid_out = state.frac_valid;
  assign frac_sig_out        = state.frac_sig;
endmodule : backplane_gapped_clock_control

//--- backplane_gapped_clock_control_test.sv
// Testbench: registers over APB, gapped frames, fractional, sync and clock modes.
// Assumes the checker is bound in and the backplane model drives the pins.
`timescale 1ns/10ps
module backplane_gapped_clock_control_test;
  import bgcc_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, tx_channel_clock_pin_in = 1'b0, tx_frame_boundary_pin_in = 1'b0;
  logic rx_data_in = 1'b0, frame_go = 1'b0, sclk_q = 1'b0, e1_q = 1'b0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic [4:0]  timeslot_id_pins_in = 5'h0, timeslot_id_pins_out, timeslot_id_pins_oe_out;
  logic pready_out, pslverr_out, ref_clock_out_t1_out, ref_clock_out_e1_out;
  logic ref_clock_rate_select_out, tx_serial_clock_pin_out, tx_serial_clock_pin_oe_out;
  logic tx_data_out, tx_data_valid_out, tx_frame_start_out, frac_data_out;
  logic frac_data_valid_out, frac_sig_out, rx_serial_clock_pin_oe_out, rx_serial_data_pin_out;
  logic tx_multiframe_sync_pin_in, tx_serial_data_pin_in, rx_serial_clock_pin_in, ser_clk;
  wire  tx_serial_clock_pin_in = tx_serial_clock_pin_oe_out ? tx_serial_clock_pin_out : ser_clk;
  logic [32:0] exp_q[$];
  logic [11:0] addr[3] = '{GAP_CTRL_ADDR, TX_IF_CTRL_ADDR, MODE_CTRL_ADDR};
  logic [7:0]  mask[3] = '{GCC_MASK, TIC_MASK, MODE_MASK};
  logic [7:0]  rstv[3] = '{GCC_RESET, TIC_RESET, MODE_RESET};
  int seed = 32'h51bd6a6e, error_cnt = 0, comparisons = 0;
  int k = 0, i, j, fcnt, vcnt, ones, scnt, ecnt, e0, e1cnt;
  logic [31:0] d;
  backplane_gapped_clock_control dut (.*);
  bgcc_backplane_model model (.frame_go_in(frame_go), .rx_clk_out(rx_serial_clock_pin_in),
    .gap_clk_out(tx_multiframe_sync_pin_in), .gap_data_out(tx_serial_data_pin_in),
    .ser_clk_out(ser_clk));
  initial
  begin
    forever #2 clk_in = !clk_in;
  end
  task automatic end_sim;
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_in);
    penable_in <= 1'b1;
    #1;
    while (pready_out !== 1'b1 && n < 50)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 50)
    begin
      error_cnt++;
      end_sim();
    end
    @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic run(input int n, input logic [1:0] ch, input logic fb);
    fcnt = 0;
    vcnt = 0;
    ones = 0;
    scnt = 0;
    ecnt = 0;
    e1cnt = 0;
    repeat (n)
    begin
      @(posedge clk_in);
      k++;
      tx_channel_clock_pin_in <= ch[1] ? k[3] : ch[0];
      tx_frame_boundary_pin_in <= fb;
      timeslot_id_pins_in <= 5'($random(seed));
      rx_data_in <= 1'($random(seed));
    end
  endtask : run
  always @(negedge clk_in)
  begin
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && exp_q.size() > 0)
      check("apb read", 64'({pslverr_out, prdata_out}), 64'(exp_q.pop_front()));
    fcnt += (frac_data_valid_out === 1'b1);
    vcnt += (tx_data_valid_out === 1'b1);
    ones += (tx_data_valid_out === 1'b1 && tx_data_out === 1'b1);
    scnt += (tx_frame_start_out === 1'b1);
    ecnt += (tx_serial_clock_pin_out === 1'b1 && !sclk_q);
    sclk_q = (tx_serial_clock_pin_out === 1'b1);
    e1cnt += (ref_clock_out_e1_out === 1'b1 && !e1_q);
    e1_q = (ref_clock_out_e1_out === 1'b1);
  end
  initial
  begin
    #380us;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      d = $random(seed);
      apb(1'b0, addr[i], 32'h0, {25'h0, rstv[i]});
      apb(1'b1, addr[i], d, 33'h0);
      apb(1'b0, addr[i], 32'h0, {25'h0, d[7:0] & mask[i]});
    end
    apb(1'b0, 12'h122, 32'h0, {1'b1, 32'h0});
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, GAP_CTRL_ADDR, {24'h0, i[0], 7'h0}, 33'h0);
      run(3, 2'b00, 1'b0);
      check("rate select", 64'(ref_clock_rate_select_out), 64'(i));
    end
    apb(1'b1, TX_IF_CTRL_ADDR, 32'h0, 33'h0);
    apb(1'b1, MODE_CTRL_ADDR, 32'h0, 33'h0);
    apb(1'b1, GAP_CTRL_ADDR, 32'h3, 33'h0);
    frame_go <= 1'b1;
    run(2300, 2'b00, 1'b0);
    frame_go <= 1'b0;
    check("gapped payload bits", 64'(vcnt), 64'd193);
    check("gapped payload ones", 64'(ones), 64'd65);
    apb(1'b1, GAP_CTRL_ADDR, 32'h0, 33'h0);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, TX_IF_CTRL_ADDR, {24'h0, i[0], 7'h10}, 33'h0);
      run(900, i ? 2'b01 : 2'b10, 1'b0);
      check("frac active", 64'(fcnt != 0), 64'd1);
      run(8, 2'b00, 1'b0);
      run(900, 2'b00, 1'b0);
      check("frac idle", 64'(fcnt), 64'd0);
    end
    apb(1'b1, MODE_CTRL_ADDR, 32'h1, 33'h0);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, TX_IF_CTRL_ADDR, {26'h0, i[0], 5'h0}, 33'h0);
      run(4, 2'b00, i[0]);
      run(40, 2'b00, i[0]);
      check("sync inactive", 64'(scnt), 64'd0);
      run(40, 2'b00, !i[0]);
      check("sync active", 64'(scnt != 0), 64'd1);
    end
    apb(1'b1, MODE_CTRL_ADDR, 32'h2, 33'h0);
    for (j = 0; j < 2; j++)
    begin
      apb(1'b1, TX_IF_CTRL_ADDR, {26'h0, j[0], 5'h0}, 33'h0);
      run(31200, 2'b00, 1'b0);
      if (j == 0)
        e0 = ecnt;
    end
    check("continuous clock", 64'(e0 >= 190 && e0 <= 196), 64'd1);
    check("payload clock gaps", 64'(ecnt < e0), 64'd1);
    check("slot number", 64'(timeslot_id_pins_out < 5'd24), 64'd1);
    check("e1 reference rate", 64'(e1cnt >= 250 && e1cnt <= 260), 64'd1);
    check("apb reads left", 64'(exp_q.size()), 64'd0);
    end_sim();
  end
endmodule : backplane_gapped_clock_control_test

//--- bgcc_backplane_model.sv
// Backplane model: gapped receive and transmit clocks, gapped data, 1.544 MHz clock.
// Assumes a frame starts at each rising edge of frame_go_in.
`timescale 1ns/10ps
module bgcc_backplane_model (
  input  wire logic frame_go_in,
  output logic      rx_clk_out,
  output logic      gap_clk_out,
  output logic      gap_data_out,
  output logic      ser_clk_out
);
  int slot;
  initial
  begin
    rx_clk_out = 1'b0;
    gap_clk_out = 1'b0;
    gap_data_out = 1'b0;
    ser_clk_out = 1'b0;
    forever
    begin
      @(posedge frame_go_in);
      #1.3;
      for (slot = 0; slot < 256; slot++)
      begin
        gap_data_out = slot[0];
        #8;
        // Slots 3, 7 .. 251 carry no clock: 63 gaps per 256 slots
        if (slot > 251 || slot % 4 != 3)
        begin
          rx_clk_out = 1'b1;
          gap_clk_out = 1'b1;
        end
        #16;
        rx_clk_out = 1'b0;
        gap_clk_out = 1'b0;
        #8;
      end
      gap_data_out = !gap_data_out;
    end
  end
  always #324 ser_clk_out = !ser_clk_out;
endmodule : bgcc_backplane_model

//--- bgcc_checker.sv
// Checker: APB handshake, register side effects, pin directions, rx gaps.
// Assumes it is bound into the top module and watches only its ports.
`timescale 1ns/10ps
module bgcc_checker
  import bgcc_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        ref_clock_rate_select_out,
  input wire logic        tx_serial_clock_pin_oe_out,
  input wire logic        tx_frame_boundary_pin_in,
  input wire logic        tx_frame_start_out,
  input wire logic [4:0]  timeslot_id_pins_oe_out,
  input wire logic        rx_serial_clock_pin_in,
  input wire logic        rx_serial_clock_pin_oe_out,
  input wire logic        rx_serial_data_pin_out
);
  typedef struct packed {
    logic       rate;
    logic       txg;
    logic       frac;
    logic       pol;
    logic [1:0] mode;
    logic [3:0] quiet;
    logic [1:0] rxq;
  } shadow_t;
  shadow_t s;
  shadow_t next_s;
  logic    wr;
  logic    mapped;
  assign wr = psel_in && penable_in && pready_out && pwrite_in;
  assign mapped = paddr_in == GAP_CTRL_ADDR || paddr_in == TX_IF_CTRL_ADDR
                  || paddr_in == MODE_CTRL_ADDR;
  always_comb
  begin
    next_s = s;
    next_s.rxq = {s.rxq[0], rx_serial_clock_pin_in};
    if (s.quiet != 4'hf)
      next_s.quiet = s.quiet + 4'h1;
    if (wr)
      next_s.quiet = 4'h0;
    if (wr && paddr_in == GAP_CTRL_ADDR)
      next_s.rate = pwdata_in[7];
    if (wr && paddr_in == GAP_CTRL_ADDR)
      next_s.txg = pwdata_in[GCC_TX_GAP_BIT];
    if (wr && paddr_in == TX_IF_CTRL_ADDR)
      next_s.frac = pwdata_in[4];
    if (wr && paddr_in == TX_IF_CTRL_ADDR)
      next_s.pol = pwdata_in[5];
    if (wr && paddr_in == MODE_CTRL_ADDR)
      next_s.mode = pwdata_in[1:0];
  end
  always_ff @(posedge clk_in or posedge sys_rst_in)
    if (sys_rst_in)
      s <= '0;
    else
      s <= next_s;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_pready_answer: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  a_pready_phase: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access phase");
  a_slverr_unmapped: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("pslverr does not match address");
  a_reserved_zero: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0
    && (paddr_in != GAP_CTRL_ADDR || (prdata_out[7:0] & ~GCC_MASK) == 8'h00))
    else $error("reserved read bits not zero");
  a_rate_follows: assert property (s.quiet > 4'h2 |-> ref_clock_rate_select_out == s.rate)
    else $error("rate select does not follow register");
  a_txclk_dir: assert property (s.quiet > 4'h2 && !s.mode[0]
    |-> tx_serial_clock_pin_oe_out == (s.mode[1] && !s.txg))
    else $error("serial clock direction wrong");
  a_rx_clk_input: assert property (!rx_serial_clock_pin_oe_out)
    else $error("receive clock pin driven");
  a_slot_pins_out: assert property (s.quiet > 4'h2 && !s.frac && !s.mode[0]
    |-> timeslot_id_pins_oe_out == 5'h1f)
    else $error("slot pins not driven");
  a_slot_pins_remap: assert property (s.quiet > 4'h2 && s.frac && !s.mode[0]
    |-> timeslot_id_pins_oe_out[1:0] == 2'b00 && timeslot_id_pins_oe_out[3:2] == 2'b11)
    else $error("slot pins not remapped");
  a_rx_data_edge: assert property ($changed(rx_serial_data_pin_out)
    |-> rx_serial_clock_pin_in && !s.rxq[1])
    else $error("receive data moved without clock edge");
  a_sync_idle: assert property ((s.quiet == 4'hf && s.mode[0]
    && tx_frame_boundary_pin_in == s.pol) [*6] |-> !tx_frame_start_out)
    else $error("frame start while boundary inactive");
endmodule : bgcc_checker
bind backplane_gapped_clock_control bgcc_checker chk (.*);

//--- bgcc_pkg.sv
// Package: register map, field positions, reset values and rates for the
// backplane gapped clock control block.
// Assumes a 250 MHz system clock and an APB register bus.
package bgcc_pkg;

  // Register indices; each byte address is four times its index
  localparam logic [11:0] GAP_CTRL_IDX    = 12'h11e;
  localparam logic [11:0] TX_IF_CTRL_IDX  = 12'h120;
  localparam logic [11:0] MODE_CTRL_IDX   = 12'h124;
  localparam logic [11:0] GAP_CTRL_ADDR   = 12'(GAP_CTRL_IDX * 4);
  localparam logic [11:0] TX_IF_CTRL_ADDR = 12'(TX_IF_CTRL_IDX * 4);
  localparam logic [11:0] MODE_CTRL_ADDR  = 12'(MODE_CTRL_IDX * 4);

  // Gapped clock control fields
  localparam int GCC_REF_RATE_BIT = 7;
  localparam int GCC_TX_GAP_BIT   = 1;
  localparam int GCC_RX_GAP_BIT   = 0;
  localparam logic [7:0] GCC_MASK  = 8'h83;
  localparam logic [7:0] GCC_RESET = 8'h00;

  // Transmit interface control fields
  localparam int TIC_FRAC_CLK_BIT = 7;
  localparam int TIC_PAYLOAD_BIT  = 5;
  localparam int TIC_FRAC_EN_BIT  = 4;
  localparam logic [7:0] TIC_MASK  = 8'hb0;
  localparam logic [7:0] TIC_RESET = 8'h00;

  // Mode control fields
  localparam int MODE_HIGH_SPEED_BIT = 0;
  localparam int MODE_TXCLK_OUT_BIT  = 1;
  localparam logic [7:0] MODE_MASK  = 8'h03;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Frame geometry of a DS-1 frame carried in 2.048 Mbit/s slots
  localparam int SLOTS_PER_FRAME    = 256;
  localparam int PAYLOAD_PER_FRAME  = 193;
  localparam int GAPS_PER_FRAME     = SLOTS_PER_FRAME - PAYLOAD_PER_FRAME;
  localparam int DS1_BITS_PER_FRAME = 193;
  localparam int DS1_FRAMES_PER_MF  = 24;

  typedef struct packed {
    logic        ref_clock_rate_select;
    logic        tx_gap_clock_enable;
    logic        rx_gap_clock_enable;
    logic        frac_clock_select;
    logic        payload_clock_enable;
    logic        frac_interface_enable;
    logic        high_speed_mode;
    logic        tx_serial_clock_is_output;
  } ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage : bgcc_pkg

//--- bgcc_rx_gap.sv
// Receive gapped data output stage, clocked by the gapped receive clock.
// Assumes the other party gaps the clock; data moves only on clock edges.
`timescale 1ns/10ps
module bgcc_rx_gap (
  input  wire logic rx_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic gap_enable_in,
  input  wire logic data_in,
  output logic      rx_serial_data_pin_out
);
  typedef struct packed {
    logic en_first;
    logic en_sync;
    logic d_first;
    logic d_sync;
    logic data;
  } rx_state_t;

  rx_state_t state;
  rx_state_t next_state;

  // Each rising edge of the gapped clock moves one bit, so gaps in the clock
  // are gaps in the data.
  always_comb
  begin
    next_state.en_first = gap_enable_in;
    next_state.en_sync  = state.en_first;
    next_state.d_first  = data_in;
    next_state.d_sync   = state.d_first;
    next_state.data     = state.en_sync ? state.d_sync : 1'b0;
  end

  always_ff @(posedge rx_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign rx_serial_data_pin_out = state.data;
endmodule : bgcc_rx_gap

//--- bgcc_sync.sv
// Two flip-flop level synchroniser.
// Assumes the input is a level from another clock domain or a pin.
`timescale 1ns/10ps
module bgcc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb
  begin
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.second;
endmodule : bgcc_sync
